// ### gpe_consts.svh
/*
 gpe_consts.svh: register indices, field positions, reset values for the gpio edge event port.
 assumes: byte address on the register bus is four times the register index.
*/
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH

// ============================================================
// register indices (byte address = index * 4)
`define GPE_IDX_PIN_FN 8'h43
`define GPE_IDX_DIR 8'h90
`define GPE_IDX_DATA 8'h91
`define GPE_IDX_CTL_LO 8'h92
`define GPE_IDX_CTL_HI 8'h97
`define GPE_IDX_SEC_HI_CLR 8'h87
`define GPE_IDX_SEC_HI_MIR 8'hf7
`define GPE_IDX_SEC_LO_CLR 8'h84
`define GPE_IDX_SEC_LO_MIR 8'hf4
`define GPE_IDX_TOP_MIR 8'ha0
`define GPE_IDX_TOP_CLR 8'ha1
`define GPE_IDX_CODEC 8'ha2

// ============================================================
// field positions
`define GPE_FN_A20 6
`define GPE_FN_UPPER 2
`define GPE_CTL_LID 6
`define GPE_CTL_RELOAD_EDGE 7
`define GPE_CODEC_SDIN2 21
`define GPE_SEC_LID_POS 4
`define GPE_SEC_LID_EV 3
`define GPE_SEC_HI_STICKY 8'he8

// ============================================================
// reset values and bus answers
`define GPE_RST_BYTE 8'h00
`define GPE_RESP_OKAY 2'h0
`define GPE_RESP_SLVERR 2'h2

`endif

// ### gpe_pkg.sv
/*
 gpe_pkg: state type of the gpio edge event port.
 assumes: gpe_consts.svh supplies the numeric constants.
*/
package gpe_pkg;

	// ============================================================
	// whole state of the port, registered in one process
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] stable;
		logic [7:0] prev;
		logic [7:0] pin_fn;
		logic [7:0] dir;
		logic [7:0] dout;
		logic [7:0] ctl_lo;
		logic [7:0] ctl_hi;
		logic codec_en;
		logic top_pm;
		logic [7:0] sec_hi;
		logic [3:0] sec_lo;
		logic lid;
		logic smi_n;
		logic reload;
		logic codec_in;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic aw_have;
		logic aw_ok;
		logic [7:0] aw_idx;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} gpe_state_t;

endpackage

// ### gpe_port.sv
/*
 gpe_port: eight-pin gpio port with edge events, lid switch, timer reload, pin sharing,
 axi4-lite register slave and active-low management interrupt.
 assumes: pins are asynchronous and pass a three-flop synchroniser; one clock aclk.
*/
// Function
// RULE1: each pin has a direction bit, zero input, one output.
// RULE2: data writes change only bits of output pins.
// RULE3: data read gives pin level for inputs, last written value for outputs.
// RULE4: control low bits 5..3 pick rising or falling edge for pins 2..0.
// RULE5: control low bits 2..0 enable pins 2..0 as interrupt sources.
// RULE6: lid mode on pin 6: each transition toggles lid status and interrupts.
// RULE7: in lid mode the lid position reads in second-level status bit 4.
// RULE8: control low bit 7 picks pin 7 edge that reloads timer two.
// RULE9: control high bits 7..4 pick edge for pins 7,5,4,3.
// RULE10: control high bits 3..0 enable pins 7,5,4,3 as interrupt sources.
// RULE11: pins 2,1,0 events set top bit 0 and second-level bits 7,6,5.
// RULE12: pins 7,5,4,3 events set top bit 0 and other status bits 3..0.
// RULE13: software sets a pin to input before using its event functions.
// RULE14: software uses pin 7 for interrupt or timer reload.
// RULE15: only pins 2..0 can wake the system with clocks stopped.
// RULE16: function bit 2 hands pins 7..4 to isa upper address bits.
// RULE17: pin 4 carries isa address bit twenty when function bit 6 or 2.
// RULE18: codec bit 21 makes pin 1 the second codec serial input.
// RULE19: interrupt output low while any status is pending.
// RULE20: top status read at clearing offset clears it; mirror read does not.
// RULE21: pins are synchronised before edge detection.
`timescale 1ns/10ps
`default_nettype none
`include "gpe_consts.svh"

module gpe_port #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// gpio pins
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe,
	// shared functions
	input wire logic [3:0] isa_upper_address_bits,
	output logic second_codec_serial_input,
	output logic general_timer_two_reload,
	// system side
	output logic system_management_interrupt_n,
	output logic suspend_wake
);
	import gpe_pkg::*;

	// ============================================================
	// state
	gpe_state_t r;
	gpe_state_t n;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] sel;
	logic [7:0] en;
	logic [7:0] usable;
	logic [7:0] ev;
	logic lid_ev;
	logic [7:0] set_hi;
	logic [3:0] set_lo;
	logic [7:0] clr_hi;
	logic [3:0] clr_lo;
	logic clr_top;
	logic ar_take;
	logic [7:0] ar_idx;
	logic ar_ok;
	logic [31:0] rd;
	logic rd_hit;
	logic [7:0] alt;
	logic [7:0] lid_bit;

	assign s_axi_awready = !r.aw_have && !r.bvalid;
	assign s_axi_wready = !r.w_have && !r.bvalid;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign gpio_out = r.pin_out;
	assign gpio_oe = r.pin_oe;
	assign second_codec_serial_input = r.codec_in;
	assign general_timer_two_reload = r.reload;
	assign system_management_interrupt_n = r.smi_n;

	// pins 2..0 wake straight from the pad level, so this path needs no clock
	assign suspend_wake = |(r.ctl_lo[2:0] & ~r.dir[2:0] & (gpio_in[2:0] ^ r.ctl_lo[5:3])); // [RULE15]

	// ============================================================
	// next state
	always_comb begin
		n = r;
		// three flops; a change counts only once the second and third agree
		n.s1 = gpio_in; // [RULE21]
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.stable = (r.stable & (r.s2 ^ r.s3)) | (r.s2 & ~(r.s2 ^ r.s3)); // [RULE21]
		n.prev = r.stable;
		rise = r.stable & ~r.prev;
		fall = ~r.stable & r.prev;

		// pins handed to isa are no longer gpio
		alt = {{3{r.pin_fn[`GPE_FN_UPPER]}},
			r.pin_fn[`GPE_FN_UPPER] | r.pin_fn[`GPE_FN_A20], 4'h0}; // [RULE16] [RULE17]
		usable = ~r.dir & ~alt; // [RULE13]
		sel = {r.ctl_hi[7], 1'b0, r.ctl_hi[6:4], r.ctl_lo[5:3]}; // [RULE4] [RULE9]
		en = {r.ctl_hi[3], 1'b0, r.ctl_hi[2:0], r.ctl_lo[2:0]}; // [RULE5] [RULE10]
		ev = en & usable & ((~sel & rise) | (sel & fall)); // [RULE4] [RULE5] [RULE9] [RULE10]
		lid_ev = r.ctl_lo[`GPE_CTL_LID] && usable[6] && (rise[6] || fall[6]); // [RULE6]
		set_hi = {ev[2:0], 1'b0, lid_ev, 3'h0}; // [RULE11] [RULE6]
		set_lo = {ev[7], ev[5:3]}; // [RULE12]

		// timer two reload pulse on the chosen pin 7 edge
		n.reload = usable[7] && (r.ctl_lo[`GPE_CTL_RELOAD_EDGE] ? fall[7] : rise[7]); // [RULE8]
		if (lid_ev) begin
			n.lid = !r.lid; // [RULE6]
		end

		// read channel; at a clearing offset the returned status bits, but not the lid position bit, are the ones that get cleared
		ar_take = s_axi_arvalid && !r.rvalid;
		ar_idx = s_axi_araddr[9:2];
		ar_ok = (s_axi_araddr[ADDR_W-1:10] == '0);
		lid_bit = 8'h00;
		lid_bit[`GPE_SEC_LID_POS] = r.ctl_lo[`GPE_CTL_LID] & r.lid; // [RULE7]
		rd = 32'h0000_0000;
		rd_hit = 1'b1;
		clr_hi = 8'h00;
		clr_lo = 4'h0;
		clr_top = 1'b0;
		case (ar_idx)
			`GPE_IDX_PIN_FN: rd[7:0] = r.pin_fn;
			`GPE_IDX_DIR: rd[7:0] = r.dir;
			`GPE_IDX_DATA: rd[7:0] = (r.dir & r.dout) | (~r.dir & r.stable); // [RULE3]
			`GPE_IDX_CTL_LO: rd[7:0] = r.ctl_lo;
			`GPE_IDX_CTL_HI: rd[7:0] = r.ctl_hi;
			`GPE_IDX_SEC_HI_CLR: begin
				rd[7:0] = r.sec_hi | lid_bit;
				clr_hi = r.sec_hi;
			end
			`GPE_IDX_SEC_HI_MIR: rd[7:0] = r.sec_hi | lid_bit; // [RULE7]
			`GPE_IDX_SEC_LO_CLR: begin
				rd[3:0] = r.sec_lo;
				clr_lo = r.sec_lo;
			end
			`GPE_IDX_SEC_LO_MIR: rd[3:0] = r.sec_lo;
			`GPE_IDX_TOP_CLR: begin
				rd[0] = r.top_pm;
				clr_top = r.top_pm; // [RULE20]
			end
			`GPE_IDX_TOP_MIR: rd[0] = r.top_pm; // [RULE20]
			`GPE_IDX_CODEC: rd[`GPE_CODEC_SDIN2] = r.codec_en;
			default: rd_hit = 1'b0;
		endcase
		if (!ar_ok) begin
			rd_hit = 1'b0;
			rd = 32'h0000_0000;
			clr_hi = 8'h00;
			clr_lo = 4'h0;
			clr_top = 1'b0;
		end
		if (!ar_take) begin
			clr_hi = 8'h00;
			clr_lo = 4'h0;
			clr_top = 1'b0;
		end
		if (ar_take) begin
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = rd_hit ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
		end else if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end

		// status: a new event in the clearing cycle survives the clear
		n.sec_hi = ((r.sec_hi & ~clr_hi) | set_hi) & `GPE_SEC_HI_STICKY; // [RULE11] [RULE20]
		n.sec_lo = (r.sec_lo & ~clr_lo) | set_lo; // [RULE12]
		n.top_pm = (r.top_pm & !clr_top) | (|set_hi) | (|set_lo); // [RULE11] [RULE12] [RULE20]
		n.smi_n = !(n.top_pm || (|n.sec_hi) || (|n.sec_lo)); // [RULE19]

		// write channel; address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_have = 1'b1;
			n.aw_idx = s_axi_awaddr[9:2];
			n.aw_ok = (s_axi_awaddr[ADDR_W-1:10] == '0);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.aw_have && r.w_have) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `GPE_RESP_OKAY;
			if (!r.aw_ok) begin
				n.bresp = `GPE_RESP_SLVERR;
			end else begin
				case (r.aw_idx)
					`GPE_IDX_PIN_FN: if (r.wstrb[0]) n.pin_fn = r.wdata[7:0];
					`GPE_IDX_DIR: if (r.wstrb[0]) n.dir = r.wdata[7:0]; // [RULE1]
					`GPE_IDX_DATA: if (r.wstrb[0]) begin
						n.dout = (r.dout & ~r.dir) | (r.wdata[7:0] & r.dir); // [RULE2]
					end
					`GPE_IDX_CTL_LO: if (r.wstrb[0]) n.ctl_lo = r.wdata[7:0];
					`GPE_IDX_CTL_HI: if (r.wstrb[0]) n.ctl_hi = r.wdata[7:0];
					`GPE_IDX_CODEC: if (r.wstrb[2]) n.codec_en = r.wdata[`GPE_CODEC_SDIN2];
					`GPE_IDX_SEC_HI_CLR, `GPE_IDX_SEC_HI_MIR, `GPE_IDX_SEC_LO_CLR,
					`GPE_IDX_SEC_LO_MIR, `GPE_IDX_TOP_CLR, `GPE_IDX_TOP_MIR: begin
						n.bresp = `GPE_RESP_OKAY;
					end
					default: n.bresp = `GPE_RESP_SLVERR;
				endcase
			end
		end else if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end

		// pin drivers; a handed-over pin follows the isa address bit
		n.pin_oe = r.dir | alt; // [RULE1] [RULE16]
		n.pin_out = r.dout & r.dir;
		if (r.pin_fn[`GPE_FN_UPPER]) begin
			n.pin_out[7:5] = isa_upper_address_bits[3:1]; // [RULE16]
		end
		if (r.pin_fn[`GPE_FN_UPPER] || r.pin_fn[`GPE_FN_A20]) begin
			n.pin_out[4] = isa_upper_address_bits[0]; // [RULE17]
		end
		// codec path still obeys the direction bit, so an output pin feeds nothing
		n.codec_in = r.codec_en & ~r.dir[1] & r.stable[1]; // [RULE18]
	end

	// ============================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.smi_n <= 1'b1;
			r.pin_fn <= `GPE_RST_BYTE;
			r.dir <= `GPE_RST_BYTE;
			r.dout <= `GPE_RST_BYTE;
			r.ctl_lo <= `GPE_RST_BYTE;
			r.ctl_hi <= `GPE_RST_BYTE;
		end else begin
			r <= n;
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_oe_follows_dir: // [RULE1]
	assert property (!r.pin_fn[`GPE_FN_UPPER] && !r.pin_fn[`GPE_FN_A20]
		|=> gpio_oe == $past(r.dir))
		else $error("output enable does not follow direction");

	a_input_write_ignored: // [RULE2]
	assert property (r.aw_have && r.w_have && r.aw_ok && r.aw_idx == `GPE_IDX_DATA
		|=> (r.dout & ~$past(r.dir)) == ($past(r.dout) & ~$past(r.dir)))
		else $error("write changed an input data bit");

	a_data_read_level: // [RULE3]
	assert property (ar_take && ar_ok && ar_idx == `GPE_IDX_DATA
		|=> s_axi_rdata[7:0] == (($past(r.dir) & $past(r.dout)) | (~$past(r.dir) & $past(r.stable))))
		else $error("data read returned wrong value");

	a_pin0_rise_event: // [RULE4]
	assert property (r.ctl_lo[0] && !r.ctl_lo[3] && !r.dir[0] && rise[0]
		|=> r.sec_hi[5] && r.top_pm ##1 !system_management_interrupt_n)
		else $error("pin 0 rising edge not reported");

	a_pin3_fall_event: // [RULE12]
	assert property (r.ctl_hi[0] && r.ctl_hi[4] && !r.dir[3] && fall[3] |=> r.sec_lo[0])
		else $error("pin 3 falling edge not reported");

	a_lid_toggle: // [RULE6]
	assert property (lid_ev |=> r.lid != $past(r.lid) && r.sec_hi[`GPE_SEC_LID_EV])
		else $error("lid transition did not toggle");

	a_reload_edge: // [RULE8]
	assert property (!r.dir[7] && !r.pin_fn[`GPE_FN_UPPER] && $fell(r.stable[7])
		&& r.ctl_lo[`GPE_CTL_RELOAD_EDGE] |=> general_timer_two_reload ##1 !general_timer_two_reload)
		else $error("timer reload pulse missing");

	a_smi_release: // [RULE19]
	assert property (!r.top_pm && r.sec_hi == 8'h00 && r.sec_lo == 4'h0 |-> system_management_interrupt_n)
		else $error("interrupt held with nothing pending");

	a_top_read_clear: // [RULE20]
	assert property (ar_take && ar_ok && ar_idx == `GPE_IDX_TOP_CLR && ev == 8'h00 && !lid_ev
		|=> !r.top_pm)
		else $error("clearing read left top status set");

	a_top_mirror_keeps: // [RULE20]
	assert property (ar_take && ar_idx == `GPE_IDX_TOP_MIR && r.top_pm |=> r.top_pm)
		else $error("mirror read cleared top status");

	a_a20_pin: // [RULE17]
	assert property (r.pin_fn[`GPE_FN_A20] |=> gpio_oe[4] && gpio_out[4] == $past(isa_upper_address_bits[0]))
		else $error("pin 4 not carrying address bit twenty");

	a_dir_write: // [RULE1]
	assert property (r.aw_have && r.w_have && r.aw_ok && r.aw_idx == `GPE_IDX_DIR && r.wstrb[0]
		|=> r.dir == $past(r.wdata[7:0]))
		else $error("direction write not applied");

	a_output_write_taken: // [RULE2]
	assert property (r.aw_have && r.w_have && r.aw_ok && r.aw_idx == `GPE_IDX_DATA
		&& r.wstrb[0]
		|=> (r.dout & $past(r.dir)) == ($past(r.wdata[7:0]) & $past(r.dir)))
		else $error("write missed an output data bit");

	a_sync_holds: // [RULE21]
	assert property (r.s2 != r.s3 |=> r.stable == $past(r.stable))
		else $error("unsettled pin reached edge detection");

	a_reload_single: // [RULE8]
	assert property (general_timer_two_reload |=> !general_timer_two_reload)
		else $error("timer reload pulse longer than one cycle");

	a_lid_position_read: // [RULE7]
	assert property (ar_take && ar_ok && ar_idx == `GPE_IDX_SEC_HI_MIR
		|=> s_axi_rdata[`GPE_SEC_LID_POS] == ($past(r.ctl_lo[`GPE_CTL_LID]) && $past(r.lid)))
		else $error("lid position read wrong");

	a_sec_mirror_keeps: // [RULE20]
	assert property (ar_take && ar_ok && ar_idx == `GPE_IDX_SEC_HI_MIR && r.sec_hi[5]
		|=> r.sec_hi[5])
		else $error("mirror read cleared second-level status");

	a_smi_pending: // [RULE19]
	assert property (r.top_pm || r.sec_hi != 8'h00 || r.sec_lo != 4'h0
		|-> !system_management_interrupt_n)
		else $error("interrupt high with status pending");

	a_wake_level: // [RULE15]
	assert property (r.ctl_lo[0] && !r.dir[0] && gpio_in[0] != r.ctl_lo[3] |-> suspend_wake)
		else $error("pin 0 at active level gives no wake");

	a_wake_quiet: // [RULE15]
	assert property (r.ctl_lo[2:0] == 3'h0 |-> !suspend_wake)
		else $error("wake raised with no pin enabled");

	a_upper_pins_out: // [RULE16]
	assert property (r.pin_fn[`GPE_FN_UPPER]
		|=> gpio_oe[7:4] == 4'hf && gpio_out[7:5] == $past(isa_upper_address_bits[3:1]))
		else $error("pins 7..5 not carrying upper address bits");

	a_codec_output_pin: // [RULE18]
	assert property (r.dir[1] |=> !second_codec_serial_input)
		else $error("codec input fed from an output pin");

endmodule // gpe_port

`default_nettype wire

// ### gpe_pad_model.sv
/*
 gpe_pad_model: switches and board logic on the eight pads.
 assumes: ext is what the switches drive; poe high means the port drives.
*/
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// pad model
module gpe_pad_model (
	// from the switches
	input wire logic [7:0] ext,
	// from the port
	input wire logic [7:0] pout,
	input wire logic [7:0] poe,
	// to the port
	output logic [7:0] pad
);
	// a driven pad shows the port, an undriven one the switch
	assign pad = (poe & pout) | (~poe & ext);
endmodule // gpe_pad_model
`default_nettype wire

// ### tb_top.sv
/*
 tb_top: random and corner tests of gpe_port over axi4-lite and its pads.
 assumes: gpe_consts.svh indices; pads come from gpe_pad_model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpe_consts.svh"
// ============================================================
// bench
module tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, f;
	logic awready, wready, bvalid, arready, rvalid, sdin2, reload, smi_n, wake;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, lfsr;
	logic [3:0] wstrb, isa;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] ext, pad, gout, goe, d, w, e, m;
	int n_errors, n_checks, cyc, n_rl, k, p, j;
	int pins[7] = '{0, 1, 2, 3, 4, 5, 7};
	logic [7:0] regs[5] = '{`GPE_IDX_DIR, `GPE_IDX_DATA, `GPE_IDX_CTL_LO, `GPE_IDX_CTL_HI,
		`GPE_IDX_PIN_FN};
	gpe_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(pad), .gpio_out(gout),
		.gpio_oe(goe), .isa_upper_address_bits(isa), .second_codec_serial_input(sdin2),
		.general_timer_two_reload(reload), .system_management_interrupt_n(smi_n),
		.suspend_wake(wake));
	gpe_pad_model pads (.ext(ext), .pout(gout), .poe(goe), .pad(pad));

	// ============================================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] exp_data(input logic [7:0] dr, wv, pv);
		return (dr & wv) | (~dr & pv);
	endfunction
	task automatic test_done();
		if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			n_errors++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// readiness is judged at the falling edge, where it has settled
	task automatic wr(input logic [7:0] ix, input logic [31:0] dv, input logic [3:0] s);
		logic a, b, c;
		@(posedge aclk);
		awaddr <= {2'h0, ix, 2'h0};
		wdata <= dv;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		c = 1'b0;
		while (!c) begin
			@(negedge aclk);
			a = awvalid && awready;
			b = wvalid && wready;
			c = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (b) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] ix);
		logic a, c;
		@(posedge aclk);
		araddr <= {2'h0, ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		c = 1'b0;
		while (!c) begin
			@(negedge aclk);
			a = arvalid && arready;
			c = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (a) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] ix, input logic [31:0] ex);
		rdr(ix);
		chk("rdata", ex, rd);
	endtask
	task automatic clr();
		rdr(`GPE_IDX_TOP_CLR);
		rdr(`GPE_IDX_SEC_HI_CLR);
		rdr(`GPE_IDX_SEC_LO_CLR);
	endtask
	task automatic smi_wait(input logic ex);
		int n;
		n = 0;
		while (smi_n !== ex && n < 20) begin
			@(negedge aclk);
			n++;
		end
		chk("smi_n", {31'h0, ex}, {31'h0, smi_n});
	endtask

	// ============================================================
	// clock, watchdog
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (reload === 1'b1) n_rl <= n_rl + 1;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end

	// ============================================================
	// scenarios
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'h0;
		isa = 4'h0;
		ext = 8'h00;
		m = 8'h00;
		lfsr = 32'h00014452;
		tick(5);
		aresetn <= 1'b1;
		for (k = 0; k < 5; k++) rchk(regs[k], 32'h0);
		chk("smi_n", 32'h1, {31'h0, smi_n});
		for (k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			d = (k == 0) ? 8'h00 : lfsr[7:0];
			w = lfsr[15:8];
			e = lfsr[23:16];
			// input bits keep what they held, so the model carries over between rounds
			m = exp_data(d, w, m);
			@(posedge aclk);
			ext <= e;
			wr(`GPE_IDX_DIR, {24'h0, d}, 4'h1);
			wr(`GPE_IDX_DATA, {24'h0, w}, 4'h1);
			tick(10);
			chk("oe", {24'h0, d}, {24'h0, goe});
			rchk(`GPE_IDX_DATA, {24'h0, exp_data(d, w, e)});
			wr(`GPE_IDX_DIR, 32'hff, 4'h1);
			tick(2);
			chk("out", {24'h0, m}, {24'h0, gout});
		end
		wr(`GPE_IDX_DIR, 32'h0, 4'h1);
		for (k = 0; k < 7; k++) begin
			p = pins[k];
			j = k - 3;
			lfsr = nxt(lfsr);
			// corner cases: pin 0 always rises, pin 3 always falls
			f = (p == 0) ? 1'b0 : ((p == 3) ? 1'b1 : lfsr[0]);
			@(posedge aclk);
			ext[p] <= f;
			tick(10);
			clr();
			if (p < 3) wr(`GPE_IDX_CTL_LO, ({31'h0, f} << (p + 3)) | (32'h1 << p), 4'h1);
			else wr(`GPE_IDX_CTL_HI, ({31'h0, f} << (j + 4)) | (32'h1 << j), 4'h1);
			@(posedge aclk);
			ext[p] <= ~f;
			smi_wait(1'b0);
			if (p < 3) chk("wake", 32'h1, {31'h0, wake});
			if (p < 3) rchk(`GPE_IDX_SEC_HI_MIR, 32'h1 << (p + 5));
			else rchk(`GPE_IDX_SEC_LO_MIR, 32'h1 << j);
			rchk(`GPE_IDX_TOP_MIR, 32'h1);
			rchk(`GPE_IDX_TOP_CLR, 32'h1);
			rchk(`GPE_IDX_TOP_MIR, 32'h0);
			clr();
			smi_wait(1'b1);
			@(posedge aclk);
			ext[p] <= f;
			tick(10);
			chk("idle", 32'h1, {31'h0, smi_n});
			wr(`GPE_IDX_CTL_LO, 32'h0, 4'h1);
			wr(`GPE_IDX_CTL_HI, 32'h0, 4'h1);
		end
		// timer reload on falling edge only
		@(posedge aclk);
		ext[7] <= 1'b1;
		wr(`GPE_IDX_CTL_LO, 32'h80, 4'h1);
		tick(10);
		j = n_rl;
		@(posedge aclk);
		ext[7] <= 1'b0;
		tick(10);
		chk("reload", j + 1, n_rl);
		@(posedge aclk);
		ext[7] <= 1'b1;
		tick(10);
		chk("reload", j + 1, n_rl);
		// lid switch, both transitions
		@(posedge aclk);
		ext[6] <= 1'b0;
		// let the pin settle first so lid mode never sees a stale edge
		tick(10);
		wr(`GPE_IDX_CTL_LO, 32'h40, 4'h1);
		tick(10);
		clr();
		@(posedge aclk);
		ext[6] <= 1'b1;
		smi_wait(1'b0);
		rchk(`GPE_IDX_SEC_HI_MIR, 32'h18);
		clr();
		@(posedge aclk);
		ext[6] <= 1'b0;
		smi_wait(1'b0);
		rchk(`GPE_IDX_SEC_HI_CLR, 32'h08);
		clr();
		wr(`GPE_IDX_CTL_LO, 32'h0, 4'h1);
		// pin sharing
		lfsr = nxt(lfsr);
		@(posedge aclk);
		isa <= lfsr[3:0];
		wr(`GPE_IDX_PIN_FN, 32'h04, 4'h1);
		tick(3);
		chk("isa_oe", 32'hf0, {24'h0, goe & 8'hf0});
		chk("isa_out", {28'h0, lfsr[3:0]}, {28'h0, gout[7:4]});
		wr(`GPE_IDX_PIN_FN, 32'h40, 4'h1);
		tick(3);
		chk("a20_oe", 32'h10, {24'h0, goe & 8'hf0});
		chk("a20_out", {31'h0, lfsr[0]}, {31'h0, gout[4]});
		wr(`GPE_IDX_PIN_FN, 32'h0, 4'h1);
		tick(3);
		chk("oe_back", 32'h0, {24'h0, goe});
		// codec input on pin 1
		@(posedge aclk);
		ext[1] <= 1'b1;
		wr(`GPE_IDX_CODEC, 32'h00200000, 4'h4);
		tick(10);
		chk("sdin2", 32'h1, {31'h0, sdin2});
		@(posedge aclk);
		ext[1] <= 1'b0;
		tick(10);
		chk("sdin2", 32'h0, {31'h0, sdin2});
		// unmapped place
		wr(8'h00, 32'hff, 4'h1);
		chk("bresp", {30'h0, `GPE_RESP_SLVERR}, {30'h0, rs});
		rdr(8'h00);
		chk("rresp", {30'h0, `GPE_RESP_SLVERR}, {30'h0, rs});
		chk("rdata", 32'h0, rd);
		// status places take writes with no effect; a write with no strobe changes nothing
		wr(`GPE_IDX_TOP_MIR, 32'h1, 4'h1);
		chk("bresp", {30'h0, `GPE_RESP_OKAY}, {30'h0, rs});
		rchk(`GPE_IDX_TOP_MIR, 32'h0);
		wr(`GPE_IDX_DIR, 32'hff, 4'h0);
		rchk(`GPE_IDX_DIR, 32'h0);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
